// File: testbench/scan_ctrl_model.sv
// controller model: walks the port state machine over tck, tms, tdi
// assumes calls start in run-test-idle; tck parks low between steps
`timescale 1ns/1ps
module scan_ctrl_model (
    // test pins
    output      scan_port_pkg::scan_in_t  scan_in,
    input  wire scan_port_pkg::scan_out_t scan_out
);
    initial scan_in = 3'b011;
    // one 400 ns step, tms and tdi move only with tck low
    task automatic step(input logic ms, input logic di, output logic dq);
        scan_in.tms = ms;
        scan_in.tdi = di;
        #200 dq = scan_out.tdo;
        scan_in.tck = 1'b1;
        #200 scan_in.tck = 1'b0;
    endtask : step
    // shift then update; callers pass defined codes only
    task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
        logic b;
        dout = '0;
        repeat (ir ? 2 : 1) step(1'b1, 1'b1, b);
        repeat (2) step(1'b0, 1'b1, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
    endtask : scan
endmodule : scan_ctrl_model

// File: testbench/scan_port_asserts.sv
// checker: test pin timing and instruction effects at the top ports
// assumes tck runs far slower than sys_clk
`timescale 1ns/1ps
module scan_port_asserts (
    // clock, reset, pins
    input wire logic                     sys_clk,
    input wire logic                     rst_n,
    input wire scan_port_pkg::scan_in_t  scan_in,
    input wire scan_port_pkg::scan_out_t scan_out,
    input wire logic                     mem_out_hiz
);
    logic       tck_r;
    logic [2:0] ones_r;
    // rises seen with tms high, saturating at five
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tck_r  <= 1'b0;
            ones_r <= 3'h0;
        end else begin
            tck_r  <= scan_in.tck;
            if (scan_in.tck && !tck_r) ones_r <= !scan_in.tms ? 3'h0 : ones_r + {2'h0, ones_r != 3'h5};
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence fifth_tms;
        scan_in.tck && !tck_r && scan_in.tms && ones_r == 3'h4;
    endsequence
    chk_tdo_fall: assert property (scan_in.tck [*3] |-> $stable(scan_out.tdo)) else $error("tdo moved");
    chk_oe_fall: assert property (scan_in.tck [*3] |-> $stable(scan_out.tdo_oe)) else $error("oe moved");
    chk_oe_enter: assert property ($rose(scan_out.tdo_oe) |-> ones_r == 3'h0) else $error("oe rose");
    chk_oe_leave: assert property ($fell(scan_out.tdo_oe) |-> ones_r != 3'h0) else $error("oe fell");
    chk_tms_reset: assert property (fifth_tms |-> ##[1:8] !mem_out_hiz) else $error("no reset");
    chk_hiz_shift: assert property ($changed(mem_out_hiz) |-> !scan_out.tdo_oe) else $error("hiz in shift");
    chk_hiz_update: assert property ($changed(mem_out_hiz) |-> ones_r != 3'h0) else $error("hiz early");
    chk_release: assert property ($rose(rst_n) |-> !scan_out.tdo_oe && !mem_out_hiz) else $error("busy");
endmodule : scan_port_asserts
bind sram_boundary_scan_tap scan_port_asserts i_chk (.sys_clk, .rst_n, .scan_in, .scan_out, .mem_out_hiz);

// File: testbench/sram_boundary_scan_tap_bench.sv
// bench: controller model on the test pins, bench drives memory pin levels
// assumes controller steps start 5 ns after a sys_clk rise
`timescale 1ns/1ps
module sram_boundary_scan_tap_bench;
    import scan_port_pkg::*;
    logic             sys_clk = 1'b0, rst_n = 1'b0, mem_out_hiz;
    logic [BSR_W-1:0] pin_levels = '0;
    logic [127:0]     got;
    scan_in_t         scan_in;
    scan_out_t        scan_out;
    int               failures = 0, checks_done = 0;
    sram_boundary_scan_tap i_sram_boundary_scan_tap (.sys_clk(sys_clk), .rst_n(rst_n), .scan_in(scan_in),
        .scan_out(scan_out), .pin_levels(pin_levels), .mem_out_hiz(mem_out_hiz));
    scan_ctrl_model i_scan_ctrl_model (.scan_in(scan_in), .scan_out(scan_out));
    initial forever #25 sys_clk = ~sys_clk;
    task automatic cmp(input string what, input logic [127:0] exp, input logic [127:0] act);
        checks_done++;
        if (act !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, act);
        end
    endtask : cmp
    task automatic report_and_stop();
        if (failures == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    task automatic load_ir(input logic [2:0] ins);
        i_scan_ctrl_model.scan(1'b1, 3, {125'h0, ins}, got);
        cmp("ir capture", 128'h1, {126'h0, got[1:0]});
    endtask : load_ir
    task automatic t_ident();
        i_scan_ctrl_model.scan(1'b0, 32, '0, got);
        cmp("id code", {96'h0, ID_CODE_DEFAULT}, got);
        cmp("tdo off", 128'h0, {127'h0, scan_out.tdo_oe});
    endtask : t_ident
    task automatic t_bypass();
        load_ir(INS_BYPASS);
        i_scan_ctrl_model.scan(1'b0, 8, 128'ha5, got);
        cmp("bypass", 128'h4a, got);
    endtask : t_bypass
    task automatic t_boundary(input logic [2:0] ins, input logic hiz);
        @(posedge sys_clk);
        #5 pin_levels = {ins, 68'h0f0f_a5a5_3c3c_9669} ^ {71{hiz}};
        load_ir(ins);
        cmp("hiz", {127'h0, hiz}, {127'h0, mem_out_hiz});
        i_scan_ctrl_model.scan(1'b0, 71, '1, got);
        cmp("pins", {57'h0, pin_levels}, got);
        cmp("hiz kept", {127'h0, hiz}, {127'h0, mem_out_hiz});
    endtask : t_boundary
    task automatic t_tms_reset();
        load_ir(INS_CAPTURE_Z);
        repeat (5) i_scan_ctrl_model.step(1'b1, 1'b1, got[0]);
        i_scan_ctrl_model.step(1'b0, 1'b1, got[0]);
        cmp("hiz reset", 128'h0, {127'h0, mem_out_hiz});
        t_ident();
    endtask : t_tms_reset
    initial begin
        repeat (16) @(posedge sys_clk);
        #5 rst_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        #5 i_scan_ctrl_model.step(1'b0, 1'b1, got[0]);
        t_ident();
        t_bypass();
        t_boundary(INS_CAPTURE_Z, 1'b1);
        t_boundary(INS_SAMPLE_Z, 1'b1);
        t_boundary(INS_SAMPLE, 1'b0);
        t_tms_reset();
        report_and_stop();
    end
endmodule : sram_boundary_scan_tap_bench

// File: verilog/scan_port_pkg.sv
// scan_port_pkg: constants and types shared by the scan test port
// assumes the test clock is sampled by a faster system clock
package scan_port_pkg;

    localparam int IR_W    = 3;
    localparam int ID_W    = 32;
    localparam int BSR_W   = 71;

    // instruction codes
    localparam logic [2:0] INS_CAPTURE_Z = 3'h0;
    localparam logic [2:0] INS_IDENT     = 3'h1;
    localparam logic [2:0] INS_SAMPLE_Z  = 3'h2;
    localparam logic [2:0] INS_SAMPLE    = 3'h4;
    localparam logic [2:0] INS_BYPASS    = 3'h7;

    localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;
    localparam logic [2:0] IR_RESET_VAL   = INS_IDENT;

    // identity value is arbitrary; bit 0 marks the presence of the register
    localparam logic [31:0] ID_CODE_DEFAULT = 32'h1234_5679;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
    } tap_state_t;

    // serial test pins as seen by the device
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } scan_in_t;

    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } scan_out_t;

endpackage : scan_port_pkg

// File: verilog/sram_boundary_scan_tap.sv
// sram_boundary_scan_tap: test access port of a pipelined sram (ir, bypass, id, boundary scan)
// assumes tck, tms, tdi come from an outside controller and are oversampled on sys_clk;
// tck must stay at most a quarter of sys_clk so both edges are seen
//
// Overview of operation
// - three-bit instruction register shifts from tdi toward tdo
// - reset and power-up load the identification instruction
// - capture-ir loads binary 01 into the two low bits
// - one-bit bypass register gives minimal path tdi to tdo
// - bypass instruction clears the bypass bit to zero
// - boundary instructions capture pin levels in capture-dr, shift in shift-dr
// - tdi enters msb, lsb drives tdo, for every register
// - identification instruction captures fixed 32-bit code, shifts it out
// - shifted instruction becomes active only at update-ir
// - all-zero instruction samples pins and forces memory outputs off
// - sample-outputs-off selects boundary register and forces memory outputs off
// - sample instruction snapshots pins without disturbing the memory
// - no preload: update-dr under sample changes nothing
// - scan logic drives no memory or pin data; it only forces memory outputs off
// - bypass instruction routes bypass bit during shift-dr
// - decode 000 capture-z, 001 ident, 010 sample-z, 100 sample, 111 bypass
// - tms high on five rising edges resets the port only
// - tms and tdi sampled on rising tck, tdo updated on falling
`timescale 1ns/1ps

module sram_boundary_scan_tap
    import scan_port_pkg::*;
#(
    parameter logic [31:0] ID_CODE = scan_port_pkg::ID_CODE_DEFAULT
) (
    // clock and reset
    input  wire logic                            sys_clk,
    input  wire logic                            rst_n,
    // test pins
    input  wire scan_port_pkg::scan_in_t         scan_in,
    output      scan_port_pkg::scan_out_t        scan_out,
    // memory pin levels to capture
    input  wire logic [scan_port_pkg::BSR_W-1:0] pin_levels,
    // memory output drivers forced off
    output      logic                            mem_out_hiz
);
    import scan_port_pkg::*;

    typedef struct packed {
        logic [1:0]       tck_s;
        logic [1:0]       tms_s;
        logic [1:0]       tdi_s;
        logic             tck_d;
        tap_state_t       st;
        logic [IR_W-1:0]  ir_sh;
        logic [IR_W-1:0]  ir;
        logic             byp;
        logic [ID_W-1:0]  id_sh;
        logic [BSR_W-1:0] bsr;
        logic             tdo;
        logic             tdo_oe;
        logic             hiz;
    } tap_regs_t;

    tap_regs_t q_r;
    tap_regs_t q_nxt;

    // next controller state for a given tms
    function automatic tap_state_t next_state(input tap_state_t s, input logic m);
        case (s)
            ST_RESET: begin
                if (m) begin
                    next_state = ST_RESET;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (m) begin
                    next_state = ST_SEL_DR;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_SEL_DR: begin
                if (m) begin
                    next_state = ST_SEL_IR;
                end else begin
                    next_state = ST_CAP_DR;
                end
            end
            ST_CAP_DR: begin
                if (m) begin
                    next_state = ST_EX1_DR;
                end else begin
                    next_state = ST_SH_DR;
                end
            end
            ST_SH_DR: begin
                if (m) begin
                    next_state = ST_EX1_DR;
                end else begin
                    next_state = ST_SH_DR;
                end
            end
            ST_EX1_DR: begin
                if (m) begin
                    next_state = ST_UPD_DR;
                end else begin
                    next_state = ST_PA_DR;
                end
            end
            ST_PA_DR: begin
                if (m) begin
                    next_state = ST_EX2_DR;
                end else begin
                    next_state = ST_PA_DR;
                end
            end
            ST_EX2_DR: begin
                if (m) begin
                    next_state = ST_UPD_DR;
                end else begin
                    next_state = ST_SH_DR;
                end
            end
            ST_UPD_DR: begin
                if (m) begin
                    next_state = ST_SEL_DR;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_SEL_IR: begin
                if (m) begin
                    next_state = ST_RESET;
                end else begin
                    next_state = ST_CAP_IR;
                end
            end
            ST_CAP_IR: begin
                if (m) begin
                    next_state = ST_EX1_IR;
                end else begin
                    next_state = ST_SH_IR;
                end
            end
            ST_SH_IR: begin
                if (m) begin
                    next_state = ST_EX1_IR;
                end else begin
                    next_state = ST_SH_IR;
                end
            end
            ST_EX1_IR: begin
                if (m) begin
                    next_state = ST_UPD_IR;
                end else begin
                    next_state = ST_PA_IR;
                end
            end
            ST_PA_IR: begin
                if (m) begin
                    next_state = ST_EX2_IR;
                end else begin
                    next_state = ST_PA_IR;
                end
            end
            ST_EX2_IR: begin
                if (m) begin
                    next_state = ST_UPD_IR;
                end else begin
                    next_state = ST_SH_IR;
                end
            end
            ST_UPD_IR: begin
                if (m) begin
                    next_state = ST_SEL_DR;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_RESET;
            end
        endcase
    endfunction : next_state

    // boundary register is the data path for all three sampling instructions
    function automatic logic uses_bsr(input logic [IR_W-1:0] i);
        uses_bsr = (i == INS_CAPTURE_Z) || (i == INS_SAMPLE_Z) || (i == INS_SAMPLE);
    endfunction : uses_bsr

    logic tck_rise;
    logic tck_fall;
    logic tms_v;
    logic tdi_v;

    always_comb begin
        tck_rise = q_r.tck_s[1] & ~q_r.tck_d;
        tck_fall = ~q_r.tck_s[1] & q_r.tck_d;
        tms_v    = q_r.tms_s[1];
        tdi_v    = q_r.tdi_s[1];
        q_nxt    = q_r;
        // two-flop synchronisers; only stage 1 is read by logic
        q_nxt.tck_s = {q_r.tck_s[0], scan_in.tck};
        q_nxt.tms_s = {q_r.tms_s[0], scan_in.tms};
        q_nxt.tdi_s = {q_r.tdi_s[0], scan_in.tdi};
        q_nxt.tck_d = q_r.tck_s[1];

        if (tck_rise) begin
            // five high tms reach reset from any state
            q_nxt.st = next_state(q_r.st, tms_v);
            // entering reset loads ident
            // done on the entering edge so the fifth tms-high rise already restores the instruction
            if (q_nxt.st == ST_RESET) begin
                q_nxt.ir = IR_RESET_VAL;
            end
            case (q_r.st)
                ST_CAP_IR: begin
                    q_nxt.ir_sh = {q_r.ir[IR_W-1:2], IR_CAPTURE_PAT};
                end
                ST_SH_IR: begin
                    q_nxt.ir_sh = {tdi_v, q_r.ir_sh[IR_W-1:1]};
                end
                ST_CAP_DR: begin
                    if (q_r.ir == INS_BYPASS) begin
                        q_nxt.byp = 1'b0;
                    end
                    if (q_r.ir == INS_IDENT) begin
                        q_nxt.id_sh = ID_CODE;
                    end
                    if (uses_bsr(q_r.ir)) begin
                        q_nxt.bsr = pin_levels;
                    end
                end
                ST_SH_DR: begin
                    case (q_r.ir)
                        INS_IDENT:  q_nxt.id_sh = {tdi_v, q_r.id_sh[ID_W-1:1]};
                        INS_BYPASS: q_nxt.byp   = tdi_v;
                        default: begin
                            if (uses_bsr(q_r.ir)) begin
                                q_nxt.bsr = {tdi_v, q_r.bsr[BSR_W-1:1]};
                            end else begin
                                // reserved codes fall back to bypass
                                q_nxt.byp = tdi_v;
                            end
                        end
                    endcase
                end
                default: begin
                end
            endcase
        end

        if (tck_fall) begin
            // activate at update
            // falling edge inside update-ir, so the new instruction is live before the next rise
            if (q_r.st == ST_UPD_IR) begin
                q_nxt.ir = q_r.ir_sh;
            end
            q_nxt.tdo_oe = (q_r.st == ST_SH_IR) || (q_r.st == ST_SH_DR);
            if (q_r.st == ST_SH_IR) begin
                q_nxt.tdo = q_r.ir_sh[0];
            end else if (q_r.ir == INS_IDENT) begin
                q_nxt.tdo = q_r.id_sh[0];
            end else if (uses_bsr(q_r.ir)) begin
                q_nxt.tdo = q_r.bsr[0];
            end else begin
                q_nxt.tdo = q_r.byp;
            end
        end

        // outputs off; nothing else reaches the memory
        q_nxt.hiz = (q_r.ir == INS_CAPTURE_Z) || (q_r.ir == INS_SAMPLE_Z);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q_r       <= '0;
            q_r.st    <= ST_RESET;
            q_r.ir    <= IR_RESET_VAL;
            q_r.ir_sh <= IR_RESET_VAL;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign scan_out.tdo    = q_r.tdo;
    assign scan_out.tdo_oe = q_r.tdo_oe;
    assign mem_out_hiz     = q_r.hiz;

endmodule : sram_boundary_scan_tap
